// >>> ahri_defs.svh
// Constants for the converter host readout interface
`ifndef AHRI_DEFS_SVH
`define AHRI_DEFS_SVH

`define AHRI_RES_W        12
`define AHRI_BYTE_W       8
`define AHRI_FIFO_DEPTH   8
`define AHRI_CNT_W        4
`define AHRI_LAST_EDGE    4'hc
`define AHRI_HI_PAD       4'h0
`define AHRI_LO_PAD       5'h00
`define AHRI_LO_OE        5'h1f
`define AHRI_PIN_RST      6'h36
`define AHRI_BUS_OE_ALL   8'hff
`define AHRI_BUS_IDLE     8'h00
`define AHRI_BIT_DOUT     7
`define AHRI_BIT_SCLK     6
`define AHRI_BIT_STRB     5

`endif

// >>> ahri_pkg.sv
// Types shared by the converter host readout interface
package ahri_pkg;
  `include "ahri_defs.svh"

  // Sampled host and clock pins, travelling together
  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic high_byte_select;
    logic interface_select;
    logic power_down_n;
    logic conv_clk;
  } ahri_pins_t;

  // Data bus pins with their enables
  typedef struct packed {
    logic [`AHRI_BYTE_W-1:0] data;
    logic [`AHRI_BYTE_W-1:0] oe;
  } ahri_bus_t;

  typedef enum logic [1:0] {
    AHRI_IDLE,
    AHRI_ARMED,
    AHRI_CONV,
    AHRI_TAIL
  } ahri_state_t;
endpackage : ahri_pkg

// >>> ahri_fifo.sv
// Result FIFO with a registered head word
`timescale 1ns/100ps
`include "ahri_defs.svh"
module ahri_fifo #(
  parameter int unsigned WIDTH = `AHRI_RES_W,
  parameter int unsigned DEPTH = `AHRI_FIFO_DEPTH
) (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output      logic             in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output      logic             out_valid,
  input  wire logic             out_ready,
  output      logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // Pointers wrap naturally, so the depth must be a power of two
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("ahri_fifo depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] head_q;
  logic [AW-1:0]    wr_q, wr_d;
  logic [AW-1:0]    rd_q, rd_d;
  logic [AW:0]      cnt_q, cnt_d;
  logic             fresh_q, fresh_d;
  logic             push;
  logic             pop;

  ////////////////////////////////////////////////////////////////////////////
  // Handshakes
  assign in_ready  = (cnt_q != (AW + 1)'(DEPTH));
  assign out_valid = (cnt_q != '0) && fresh_q;
  assign out_data  = head_q;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Next pointers; head is stale for a cycle when its slot is being written
  always_comb begin
    wr_d    = push ? wr_q + AW'(1) : wr_q;
    rd_d    = pop ? rd_q + AW'(1) : rd_q;
    cnt_d   = cnt_q + (AW + 1)'(push) - (AW + 1)'(pop);
    fresh_d = !(push && (wr_q == rd_d));
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      wr_q    <= '0;
      rd_q    <= '0;
      cnt_q   <= '0;
      fresh_q <= 1'b0;
    end else begin
      wr_q    <= wr_d;
      rd_q    <= rd_d;
      cnt_q   <= cnt_d;
      fresh_q <= fresh_d;
    end
  end

  // Storage and registered read port
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
    head_q <= mem_q[rd_d];
  end
endmodule : ahri_fifo

// >>> ahri_core.sv
// Digital readout and conversion control of the 12-bit converter
`timescale 1ns/100ps
`include "ahri_defs.svh"
// Contract
// [R1] Slow-memory: low byte, then zero-padded upper nibble
// [R2] ROM: old low, new nibble, new low
// [R3] Host reads on clock after busy returns
// [R4] Post-busy reads: low byte, then padded nibble
// [R5] Select low means serial; chip-select fall samples
// [R6] Serial conversion starts on next clock fall
// [R7] Output floats until start; leading zero, strobe
// [R8] Serial bits change on falling clock edge
// [R9] Zeros follow the data until deselect
// [R10] Clock output follows the converter clock
// [R11] Deselected: serial outputs all float
// [R12] Read strobe enables clock output and strobe
// [R13] Byte select high: clock runs always
// [R14] Idle-low host: two bytes per result
// [R15] Idle-high host: zero, twelve bits, three zeros
// [R16] Frame host captures after strobe falls
// [R17] Frame host word: twelve bits, four zeros
// [R18] Host discards first conversion after power-up
// [R19] Power-down stops converter, keeps reference
// [R20] Busy rises on thirteenth clock fall
// [R21] Start needs all three low; no restart
// [R22] Result latch holds until next completion
module ahri_core
  import ahri_pkg::*;
#(
  parameter int unsigned FIFO_DEPTH = `AHRI_FIFO_DEPTH
) (
  input  wire logic                   core_clk,
  input  wire logic                   rst,
  input  wire logic                   cs_n,
  input  wire logic                   rd_n,
  input  wire logic                   high_byte_select,
  input  wire logic                   interface_select,
  input  wire logic                   power_down_n,
  input  wire logic                   conv_clk,
  input  wire logic [`AHRI_RES_W-1:0] sar_code,
  output      logic [`AHRI_BYTE_W-1:0] data_out,
  output      logic [`AHRI_BYTE_W-1:0] data_oe,
  output      logic                   busy_n,
  output      logic                   analog_enable
);
  ahri_pins_t              pin_raw;
  ahri_pins_t              pin_s1_q, pin_s2_q, pin_d_q;
  logic [`AHRI_RES_W-1:0]  code_s1_q, code_s2_q;
  ahri_state_t             state_q, state_d;
  logic [`AHRI_CNT_W-1:0]  cnt_q, cnt_d;
  logic [`AHRI_RES_W-1:0]  shift_q, shift_d;
  logic [`AHRI_RES_W-1:0]  res_q, res_d;
  logic [`AHRI_RES_W-1:0]  latch_q, latch_d;
  logic                    dout_q, dout_d;
  logic                    strobe_q, strobe_d;
  ahri_bus_t               bus_q, bus_d;
  logic                    cclk_fall;
  logic                    cs_fall;
  logic                    par_cond, par_cond_prev, par_start;
  logic                    serial;
  logic                    powered;
  logic                    reading;
  logic                    busy;
  logic                    push;
  logic                    fifo_in_ready;
  logic                    fifo_out_valid;
  logic                    fifo_pop;
  logic [`AHRI_RES_W-1:0]  fifo_out_data;
  logic                    sclk_lvl;

  if (FIFO_DEPTH < 2) begin : g_bad_depth
    $error("ahri_core needs a result FIFO of at least 2 words");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; only the second stage and its delayed copy are read
  always_comb begin
    pin_raw.cs_n             = cs_n;
    pin_raw.rd_n             = rd_n;
    pin_raw.high_byte_select = high_byte_select;
    pin_raw.interface_select = interface_select;
    pin_raw.power_down_n     = power_down_n;
    pin_raw.conv_clk         = conv_clk;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pin_s1_q  <= `AHRI_PIN_RST;
      pin_s2_q  <= `AHRI_PIN_RST;
      pin_d_q   <= `AHRI_PIN_RST;
      code_s1_q <= '0;
      code_s2_q <= '0;
    end else begin
      pin_s1_q  <= pin_raw;
      pin_s2_q  <= pin_s1_q;
      pin_d_q   <= pin_s2_q;
      code_s1_q <= sar_code;
      code_s2_q <= code_s1_q;
    end
  end

  // Edge and mode decode on synchronised pins
  assign cclk_fall     = pin_d_q.conv_clk && !pin_s2_q.conv_clk;
  assign cs_fall       = pin_d_q.cs_n && !pin_s2_q.cs_n;
  assign serial        = !pin_s2_q.interface_select;                  // R5
  assign powered       = pin_s2_q.power_down_n;
  assign par_cond      = !pin_s2_q.cs_n && !pin_s2_q.rd_n && !pin_s2_q.high_byte_select;
  assign par_cond_prev = !pin_d_q.cs_n && !pin_d_q.rd_n && !pin_d_q.high_byte_select;
  assign par_start     = par_cond && !par_cond_prev;                  // R21
  assign reading       = !pin_s2_q.cs_n && !pin_s2_q.rd_n;
  assign busy          = (state_q == AHRI_CONV);
  assign analog_enable = powered;                                     // R19

  ////////////////////////////////////////////////////////////////////////////
  // Conversion sequencer; a full FIFO holds off new conversions
  always_comb begin
    state_d  = state_q;
    cnt_d    = cnt_q;
    shift_d  = shift_q;
    res_d    = res_q;
    dout_d   = dout_q;
    strobe_d = strobe_q;
    push     = 1'b0;
    case (state_q)
      AHRI_IDLE: begin
        dout_d   = 1'b0;
        strobe_d = 1'b0;
        if (serial && cs_fall && fifo_in_ready) begin
          state_d = AHRI_ARMED;                                       // R5
          res_d   = code_s2_q;
        end else if (!serial && par_start && fifo_in_ready) begin
          state_d = AHRI_CONV;                                        // R21
          cnt_d   = '0;
          res_d   = code_s2_q;
        end
      end
      AHRI_ARMED: begin
        if (pin_s2_q.cs_n) begin
          state_d = AHRI_IDLE;
        end else if (cclk_fall) begin
          state_d  = AHRI_CONV;                                       // R6
          cnt_d    = '0;
          shift_d  = res_q;
          dout_d   = 1'b0;                                            // R7
          strobe_d = 1'b1;                                            // R7
        end
      end
      AHRI_CONV: begin
        // No start branch here: a running conversion cannot restart
        if (cclk_fall) begin
          cnt_d    = cnt_q + `AHRI_CNT_W'(1);
          strobe_d = 1'b0;
          dout_d   = shift_q[`AHRI_RES_W-1];                          // R8
          shift_d  = {shift_q[`AHRI_RES_W-2:0], 1'b0};                // R14 R15 R17
          if (cnt_q == `AHRI_LAST_EDGE) begin
            push    = 1'b1;                                           // R20
            state_d = serial ? AHRI_TAIL : AHRI_IDLE;
          end
        end
      end
      AHRI_TAIL: begin
        dout_d = 1'b0;                                                // R9
        if (pin_s2_q.cs_n) begin
          state_d = AHRI_IDLE;
        end
      end
      default: begin
        state_d = AHRI_IDLE;
      end
    endcase
    // Power-down abandons any conversion in flight
    if (!powered) begin
      state_d  = AHRI_IDLE;                                           // R19
      dout_d   = 1'b0;
      strobe_d = 1'b0;
      push     = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q  <= AHRI_IDLE;
      cnt_q    <= '0;
      shift_q  <= '0;
      res_q    <= '0;
      dout_q   <= 1'b0;
      strobe_q <= 1'b0;
    end else begin
      state_q  <= state_d;
      cnt_q    <= cnt_d;
      shift_q  <= shift_d;
      res_q    <= res_d;
      dout_q   <= dout_d;
      strobe_q <= strobe_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Completed results queue up before the output latch
  ahri_fifo #(
    .WIDTH (`AHRI_RES_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .core_clk  (core_clk),
    .rst       (rst),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .in_data   (res_q),
    .out_valid (fifo_out_valid),
    .out_ready (1'b1),
    .out_data  (fifo_out_data)
  );

  // Latch takes each result at once: a slow-memory read held through
  // the conversion must see the new bytes as soon as busy returns
  assign fifo_pop = fifo_out_valid;

  always_comb begin
    latch_d = fifo_pop ? fifo_out_data : latch_q;                     // R22
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      latch_q <= '0;
    end else begin
      latch_q <= latch_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin driver; clock output mirrors the synchronised converter clock while byte select is high or busy
  assign sclk_lvl = (pin_s2_q.high_byte_select || busy) && pin_s2_q.conv_clk; // R13

  always_comb begin
    bus_d.data = `AHRI_BUS_IDLE;
    bus_d.oe   = `AHRI_BUS_IDLE;
    if (pin_s2_q.cs_n) begin
      bus_d.oe = `AHRI_BUS_IDLE;                                      // R11
    end else if (!serial) begin
      if (!pin_s2_q.rd_n) begin
        bus_d.oe = `AHRI_BUS_OE_ALL;
        if (pin_s2_q.high_byte_select) begin
          bus_d.data = {`AHRI_HI_PAD, latch_q[`AHRI_RES_W-1:`AHRI_BYTE_W]}; // R1 R2 R4
        end else begin
          bus_d.data = latch_q[`AHRI_BYTE_W-1:0];                     // R1 R2 R4
        end
      end
    end else begin
      bus_d.data = {dout_q, sclk_lvl, strobe_q, `AHRI_LO_PAD};         // R10
      bus_d.oe   = {(state_q == AHRI_CONV) || (state_q == AHRI_TAIL), // R7
                    !pin_s2_q.rd_n, !pin_s2_q.rd_n, `AHRI_LO_OE};     // R12
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      bus_q  <= '0;
      busy_n <= 1'b1;
    end else begin
      bus_q  <= bus_d;
      busy_n <= !(state_d == AHRI_CONV);                              // R20
    end
  end

  assign data_out = bus_q.data;
  assign data_oe  = bus_q.oe;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_serial_start;
    (state_q == AHRI_ARMED) && !pin_s2_q.cs_n && cclk_fall && powered;
  endsequence

  sequence s_frame_open;
    strobe_q && !dout_q && busy;
  endsequence

  a_frame_strobe: assert property (@(posedge core_clk) disable iff (rst) // R7
    s_serial_start |=> s_frame_open ##1 !pin_d_q.cs_n |-> data_out[`AHRI_BIT_STRB])
    else $error("frame strobe not raised with leading zero");

  a_done_edge: assert property (@(posedge core_clk) disable iff (rst) // R20
    busy && cclk_fall && (cnt_q == `AHRI_LAST_EDGE) && powered |=> busy_n && !busy)
    else $error("busy did not return on the thirteenth falling edge");

  a_no_restart: assert property (@(posedge core_clk) disable iff (rst) // R21
    busy && !cclk_fall && powered |=> busy && $stable(cnt_q) && $stable(res_q))
    else $error("running conversion was disturbed");

  a_hi_byte_pad: assert property (@(posedge core_clk) disable iff (rst) // R1
    !serial && reading && pin_s2_q.high_byte_select
      |=> data_oe == `AHRI_BUS_OE_ALL && data_out == {`AHRI_HI_PAD, $past(latch_q[`AHRI_RES_W-1:`AHRI_BYTE_W])})
    else $error("upper nibble read is wrong");

  a_lo_byte_read: assert property (@(posedge core_clk) disable iff (rst) // R4
    !serial && reading && !pin_s2_q.high_byte_select |=> data_out == $past(latch_q[`AHRI_BYTE_W-1:0]))
    else $error("low byte read is wrong");

  a_deselect_float: assert property (@(posedge core_clk) disable iff (rst) // R11
    pin_s2_q.cs_n |=> data_oe == `AHRI_BUS_IDLE)
    else $error("pins driven while deselected");

  a_rd_high_float: assert property (@(posedge core_clk) disable iff (rst) // R12
    serial && !pin_s2_q.cs_n && pin_s2_q.rd_n |=> !data_oe[`AHRI_BIT_SCLK] && !data_oe[`AHRI_BIT_STRB])
    else $error("clock output or strobe driven with read strobe high");

  a_tail_zero: assert property (@(posedge core_clk) disable iff (rst) // R9
    state_q == AHRI_TAIL |=> !dout_q)
    else $error("trailing bit not zero");

  a_power_down: assert property (@(posedge core_clk) disable iff (rst) // R19
    !powered |=> !busy ##1 busy_n)
    else $error("conversion kept running in power-down");

  a_latch_hold: assert property (@(posedge core_clk) disable iff (rst) // R22
    busy [*2] |=> $stable(latch_q))
    else $error("result latch changed during a conversion");
endmodule : ahri_core

// >>> ahri_host_model.sv
// Host model: byte reads on the parallel bus and serial frame capture
`timescale 1ns/100ps
module ahri_host_model (
  input  wire logic       core_clk,
  input  wire logic       conv_clk,
  input  wire logic [7:0] data_out,
  input  wire logic [7:0] data_oe,
  input  wire logic       busy_n,
  output      logic       cs_n,
  output      logic       rd_n,
  output      logic       high_byte_select
);
  logic [23:0] s_dout;
  logic [23:0] s_strb;
  logic [23:0] s_oe;

  // Deselected and idle until the bench asks for a transfer
  initial begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    high_byte_select = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pins move just after an edge so no half-set request is sampled
  task set_pins(input logic cs, input logic rd, input logic hbs);
    @(posedge core_clk);
    #1;
    cs_n = cs;
    rd_n = rd;
    high_byte_select = hbs;
  endtask : set_pins

  // Byte read held past the sync latency, then released
  task par_read(input logic hbs, output logic [7:0] d, output logic b);
    set_pins(1'b0, 1'b0, hbs);
    repeat (5) @(posedge core_clk);
    #1;
    d = data_out;
    b = busy_n;
    set_pins(1'b1, 1'b1, hbs);
    repeat (4) @(posedge core_clk);
    #1;
  endtask : par_read

  // Bits sampled after each link rise; data settles late, so wait 2 cycles
  task serial_frame();
    set_pins(1'b0, 1'b0, 1'b0);
    for (int i = 0; i < 24; i++) begin
      @(posedge conv_clk);
      repeat (2) @(posedge core_clk);
      #1;
      s_dout[23-i] = data_out[7];
      s_strb[23-i] = data_out[5] & data_oe[5];
      s_oe[23-i] = data_oe[7];
    end
  endtask : serial_frame
endmodule : ahri_host_model

// >>> ahri_core_test.sv
// Self-checking bench for the converter host readout interface
`timescale 1ns/100ps
module ahri_core_test;
  logic        core_clk;
  logic        rst;
  logic        cs_n;
  logic        rd_n;
  logic        hbs;
  logic        interface_select;
  logic        power_down_n;
  logic        conv_clk;
  logic [11:0] sar_code;
  logic [7:0]  data_out;
  logic [7:0]  data_oe;
  logic        busy_n;
  logic        analog_enable;
  int          failures;
  int          n_tests;
  int          n;
  int          k;
  logic [7:0]  rb;
  logic        bz;
  logic        pre;
  logic [19:0] w;

  // Core clock, 50 ns
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // Converter clock, 400 ns, offset so its edges never meet core edges
  initial begin
    conv_clk = 1'b0;
    #13;
    forever #200 conv_clk = ~conv_clk;
  end

  ahri_core dut (
    .core_clk         (core_clk),
    .rst              (rst),
    .cs_n             (cs_n),
    .rd_n             (rd_n),
    .high_byte_select (hbs),
    .interface_select (interface_select),
    .power_down_n     (power_down_n),
    .conv_clk         (conv_clk),
    .sar_code         (sar_code),
    .data_out         (data_out),
    .data_oe          (data_oe),
    .busy_n           (busy_n),
    .analog_enable    (analog_enable)
  );

  ahri_host_model host (
    .core_clk         (core_clk),
    .conv_clk         (conv_clk),
    .data_out         (data_out),
    .data_oe          (data_oe),
    .busy_n           (busy_n),
    .cs_n             (cs_n),
    .rd_n             (rd_n),
    .high_byte_select (hbs)
  );

  //////////////////////////////////////////////////////////////////////////////
  // One compare for every kind of result, zero-extended to the widest
  task chk(input string nm, input logic [19:0] exp, input logic [19:0] got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task idle(input int c);
    repeat (c) @(posedge core_clk);
    #1;
  endtask : idle

  // Bounded wait for end of conversion, then room for the latch update
  task wait_busy(output int cnt);
    cnt = 0;
    while (busy_n !== 1'b1 && cnt < 400) begin
      idle(1);
      cnt++;
    end
    if (cnt >= 400) failures++;
    idle(6);
  endtask : wait_busy

  // Counts edges of the clock output bit over six link periods
  task toggles(output int c);
    logic last;
    c = 0;
    last = data_out[6];
    repeat (48) begin
      idle(1);
      if (data_out[6] !== last) c++;
      last = data_out[6];
    end
  endtask : toggles

  task test_done();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done

  //////////////////////////////////////////////////////////////////////////////
  // Hang guard, well beyond the roughly 1000 cycles the tests need
  initial begin
    #(50 * 20000);
    failures++;
    test_done();
  end

  // Main sequence
  initial begin
    failures = 0;
    n_tests = 0;
    rst = 1'b1;
    interface_select = 1'b1;
    power_down_n = 1'b1;
    sar_code = 12'ha5c;
    idle(8);
    rst = 1'b0;
    chk("busy_n after reset", 1'b1, busy_n);
    chk("data_oe after reset", 8'h00, data_oe);
    chk("analog_enable after reset", 1'b1, analog_enable);
    idle(4);
    // Held read, data unchecked as a dummy first conversion
    host.set_pins(1'b0, 1'b0, 1'b0);
    idle(4);
    chk("busy at start", 1'b0, busy_n);
    chk("data_oe in read", 8'hff, data_oe);
    wait_busy(n);
    chk("conversion length", 1'b1, n >= 92 && n <= 112);
    host.set_pins(1'b1, 1'b1, 1'b0);
    idle(6);
    // Slow-memory: one read held through the whole conversion
    sar_code = 12'h3e7;
    host.set_pins(1'b0, 1'b0, 1'b0);
    idle(4);
    chk("read starts conversion", 1'b0, busy_n);
    chk("old low during conversion", 8'h5c, data_out);
    wait_busy(n);
    chk("slow low byte", 8'he7, data_out);
    host.set_pins(1'b1, 1'b1, 1'b0);
    idle(6);
    host.par_read(1'b1, rb, bz);
    chk("slow high nibble", 8'h03, rb);
    sar_code = 12'h1b4;
    host.par_read(1'b0, rb, bz);
    chk("rom old low", 8'he7, rb);
    wait_busy(n);
    sar_code = 12'h82d;
    host.par_read(1'b1, rb, bz);
    chk("rom new nibble", 8'h01, rb);
    chk("high read no start", 1'b1, bz);
    host.par_read(1'b0, rb, bz);
    chk("rom new low", 8'hb4, rb);
    wait_busy(n);
    @(posedge conv_clk);
    host.par_read(1'b0, rb, bz);
    chk("post busy low", 8'h2d, rb);
    host.par_read(1'b1, rb, bz);
    chk("post busy nibble", 8'h08, rb);
    wait_busy(n);
    // Powered down: converter off and starts refused
    power_down_n = 1'b0;
    idle(4);
    chk("analog_enable down", 1'b0, analog_enable);
    host.par_read(1'b0, rb, bz);
    chk("no start powered down", 1'b1, bz);
    power_down_n = 1'b1;
    // Serial frame from chip-select fall
    interface_select = 1'b0;
    sar_code = 12'hc93;
    idle(4);
    host.serial_frame();
    k = 99;
    pre = 1'b0;
    for (int i = 0; i < 24; i++) begin
      if (k == 99 && host.s_strb[23-i]) k = i;
      if (k == 99) pre = pre | host.s_oe[23-i];
    end
    chk("strobe sample index", 1'b1, k <= 2);
    if (k > 3) k = 3;
    chk("dout float before start", 1'b0, pre);
    chk("strobe one period", 1'b0, host.s_strb[22-k]);
    w = host.s_dout[23-k -: 20];
    chk("serial word", {1'b0, 12'hc93, 7'h00}, w);
    chk("frame word", {12'hc93, 4'h0}, host.s_dout[22-k -: 16]);
    toggles(n);
    chk("clock out stopped", 1'b1, n == 0);
    host.set_pins(1'b0, 1'b0, 1'b1);
    toggles(n);
    chk("clock out free", 1'b1, n >= 10);
    host.set_pins(1'b0, 1'b1, 1'b1);
    idle(5);
    chk("read high floats", 3'b100, data_oe[7:5]);
    chk("trailing zero", 1'b0, data_out[7]);
    host.set_pins(1'b1, 1'b1, 1'b0);
    idle(5);
    chk("deselect floats", 3'b000, data_oe[7:5]);
    interface_select = 1'b1;
    idle(6);
    host.par_read(1'b1, rb, bz);
    chk("serial result kept", 8'h0c, rb);
    test_done();
  end
endmodule : ahri_core_test
